// ===== pkg/fp_alt_timing_pkg.sv
/*
 * Constants, field positions and carrier types for the flat panel
 * extension register slice.
 * Assumes an index/data extension register port and timing events that
 * arrive from display logic clocked by the same core clock.
 */
package fp_alt_timing_pkg;

	// Extension register indexes.
	localparam logic [7:0] IDX_ALT_ROW_OFFSET    = 8'h1e;
	localparam logic [7:0] IDX_VIRTUAL_SWITCH    = 8'h1f;
	localparam logic [7:0] IDX_TALL_FONT_MAX     = 8'h24;
	localparam logic [7:0] IDX_NINE_DOT_WIDTH    = 8'h25;
	localparam logic [7:0] IDX_SYNC_START_OFFSET = 8'h26;
	localparam logic [7:0] IDX_VIDEO_IF_CTRL     = 8'h28;
	localparam logic [7:0] IDX_HALF_LINE_VALUE   = 8'h29;
	localparam logic [7:0] IDX_SOFTWARE_FLAGS    = 8'h2b;
	localparam logic [7:0] IDX_FRAME_MARKER_DLY  = 8'h2c;
	localparam logic [7:0] IDX_LP_DELAY_COMP     = 8'h2d;
	localparam logic [7:0] IDX_LP_DELAY_NINE     = 8'h2e;
	localparam logic [7:0] IDX_LP_WIDTH_CTRL     = 8'h2f;

	// Writable bit masks; zero bits are reserved and read as zero.
	localparam logic [7:0] MASK_VIRTUAL_SWITCH = 8'h8f;
	localparam logic [7:0] MASK_VIDEO_IF_CTRL  = 8'hf2;
	localparam logic [7:0] MASK_FULL           = 8'hff;

	localparam logic [7:0] RESET_VALUE = 8'h00;

	// Virtual switch register fields.
	localparam int VSW_SENSE_SELECT = 7;

	// Video interface control fields.
	localparam int VIF_BLANK_DE_SEL   = 1;
	localparam int VIF_EIGHT_BIT_PATH = 4;
	localparam int VIF_INTERLACE      = 5;
	localparam int VIF_PAN_FULL       = 6;
	localparam int VIF_TALL_FONT_A    = 7;

	// Line pulse width/control fields.
	localparam int LPW_WIDTH_MSB     = 3;
	localparam int LPW_NINE_DLY_MSB  = 4;
	localparam int LPW_COMP_DLY_MSB  = 5;
	localparam int LPW_LP_DLY_OFF    = 6;
	localparam int LPW_FM_DLY_OFF    = 7;

	localparam int TALL_FONT_MSB = 4;

	// Frame marker length in lines.
	localparam logic [1:0] FM_LINES_SINGLE = 2'h1;
	localparam logic [1:0] FM_LINES_DUAL   = 2'h2;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] index;
		logic [7:0] data;
	} reg_access_type;

	typedef struct packed {
		logic charClkEn;
		logic hsyncPulse;
		logic fpVsyncPulse;
		logic fpBlankEndPulse;
	} timing_events_type;

	typedef struct packed {
		logic flatPanel;
		logic dualDrivePanel;
		logic hCompress;
		logic nineDotText;
		logic syncOffsetEn;
	} panel_mode_type;

	typedef enum logic [2:0] {
		PULSE_IDLE   = 3'b001,
		PULSE_DELAY  = 3'b010,
		PULSE_ACTIVE = 3'b100
	} pulse_state_type;

endpackage

// ===== verilog/flat_panel_alt_timing_regs.sv
/*
 * Extension register slice of a flat panel / CRT display controller:
 * alternate offsets, virtual switch readback, video path options and the
 * frame marker and line pulse generators for the panel.
 * Assumes the index/data port, the timing event pulses and the mode
 * inputs all come from logic on core_clk; events are one-cycle pulses.
 */
// Function
// - Alternate row offset drives all panel and emulation modes, stored as actual minus one.
// - Sense select set returns virtual switch bit chosen by misc bits 3-2.
// - Sense select clear, its default, returns the RGB comparator output.
// - Tall-font scanlines field holds five bits, scanlines per row minus one.
// - Flat panel adds sync start offset to standard sync start when control bit 2.
// - In CRT mode bit 1 picks palette blanking from blank or display enable.
// - Bit 4 picks four or eight bit path; software clears graphics bit 5.
// - With eight bit path, bit 6 picks panning bits 2-1 or 2-0.
// - Bit 5 selects interlace in CRT graphics; half-line value positions odd vsync.
// - Bit 7 picks tall-font replication pattern.
// - Frame marker rises a programmed count of hsyncs after panel vsync edge.
// - Frame marker lasts one line on single-drive, two on dual-drive panels.
// - Frame marker delay disable makes external edge coincide with internal edge.
// - Compressed line pulse delay is nine bits, bit 8 from control bit 5.
// - Nine-dot line pulse delay uses its register plus control bit 4.
// - Line pulse lasts width field plus one character clocks.
// - Line pulse delay disable makes it rise at the blank inactive edge.
// - Software flags register is eight plain storage bits.
module flat_panel_alt_timing_regs (
	input  wire logic                                core_clk,
	input  wire logic                                reset_n,
	input  wire fp_alt_timing_pkg::reg_access_type   regAccess,
	input  wire fp_alt_timing_pkg::timing_events_type timingEvents,
	input  wire fp_alt_timing_pkg::panel_mode_type   panelMode,
	input  wire logic                                crtGraphicsMode,
	input  wire logic [1:0]                          miscSenseSel,
	input  wire logic                                senseComparator,
	input  wire logic [8:0]                          stdHsyncStart,
	input  wire logic [7:0]                          stdRowOffset,
	output logic [7:0]                               regReadData,
	output logic                                     senseStatusBit,
	output logic [9:0]                               hsyncStartEff,
	output logic [8:0]                               rowOffsetActual,
	output logic [4:0]                               tallFontScanlines,
	output logic                                     tallFontA,
	output logic [7:0]                               nineDotVirtualWidth,
	output logic                                     paletteBlankByDe,
	output logic                                     eightBitPath,
	output logic [2:0]                               panningMask,
	output logic                                     interlaceEn,
	output logic [7:0]                               halfLineValue,
	output logic                                     frameMarker,
	output logic                                     linePulse
);
	import fp_alt_timing_pkg::*;

	function automatic logic hit(input logic [7:0] index,
		input logic [7:0] target);
		hit = (index == target);
	endfunction

	logic [7:0] altRowOffset_reg;
	logic [7:0] virtualSwitch_reg;
	logic [7:0] tallFontMax_reg;
	logic [7:0] nineDotWidth_reg;
	logic [7:0] syncStartOffset_reg;
	logic [7:0] videoIfCtrl_reg;
	logic [7:0] halfLine_reg;
	logic [7:0] softwareFlags_reg;
	logic [7:0] frameMarkerDelay_reg;
	logic [7:0] lpDelayComp_reg;
	logic [7:0] lpDelayNine_reg;
	logic [7:0] lpWidthCtrl_reg;

	wire        wr = regAccess.write;
	wire [7:0]  wd = regAccess.data;
	wire [7:0]  ix = regAccess.index;

	// Reserved read-zero bits are never stored, so they cannot read back.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			altRowOffset_reg     <= RESET_VALUE;
			virtualSwitch_reg    <= RESET_VALUE;
			tallFontMax_reg      <= RESET_VALUE;
			nineDotWidth_reg     <= RESET_VALUE;
			syncStartOffset_reg  <= RESET_VALUE;
			videoIfCtrl_reg      <= RESET_VALUE;
			halfLine_reg         <= RESET_VALUE;
			softwareFlags_reg    <= RESET_VALUE;
			frameMarkerDelay_reg <= RESET_VALUE;
			lpDelayComp_reg      <= RESET_VALUE;
			lpDelayNine_reg      <= RESET_VALUE;
			lpWidthCtrl_reg      <= RESET_VALUE;
		end else if (wr) begin
			if (hit(ix, IDX_ALT_ROW_OFFSET))    altRowOffset_reg <= wd;
			if (hit(ix, IDX_VIRTUAL_SWITCH))
				virtualSwitch_reg <= wd & MASK_VIRTUAL_SWITCH;
			if (hit(ix, IDX_TALL_FONT_MAX))     tallFontMax_reg <= wd;
			if (hit(ix, IDX_NINE_DOT_WIDTH))    nineDotWidth_reg <= wd;
			if (hit(ix, IDX_SYNC_START_OFFSET)) syncStartOffset_reg <= wd;
			if (hit(ix, IDX_VIDEO_IF_CTRL))
				videoIfCtrl_reg <= wd & MASK_VIDEO_IF_CTRL;
			if (hit(ix, IDX_HALF_LINE_VALUE))   halfLine_reg <= wd;
			if (hit(ix, IDX_SOFTWARE_FLAGS))
				softwareFlags_reg <= wd;
			if (hit(ix, IDX_FRAME_MARKER_DLY))  frameMarkerDelay_reg <= wd;
			if (hit(ix, IDX_LP_DELAY_COMP))     lpDelayComp_reg <= wd;
			if (hit(ix, IDX_LP_DELAY_NINE))     lpDelayNine_reg <= wd;
			if (hit(ix, IDX_LP_WIDTH_CTRL))     lpWidthCtrl_reg <= wd;
		end
	end

	// Read selection; unmapped indexes answer zero.
	logic [7:0] readNext;
	always_comb begin
		unique case (ix)
			IDX_ALT_ROW_OFFSET:    readNext = altRowOffset_reg;
			IDX_VIRTUAL_SWITCH:    readNext = virtualSwitch_reg;
			IDX_TALL_FONT_MAX:     readNext = tallFontMax_reg;
			IDX_NINE_DOT_WIDTH:    readNext = nineDotWidth_reg;
			IDX_SYNC_START_OFFSET: readNext = syncStartOffset_reg;
			IDX_VIDEO_IF_CTRL:     readNext = videoIfCtrl_reg;
			IDX_HALF_LINE_VALUE:   readNext = halfLine_reg;
			IDX_SOFTWARE_FLAGS:    readNext = softwareFlags_reg;
			IDX_FRAME_MARKER_DLY:  readNext = frameMarkerDelay_reg;
			IDX_LP_DELAY_COMP:     readNext = lpDelayComp_reg;
			IDX_LP_DELAY_NINE:     readNext = lpDelayNine_reg;
			IDX_LP_WIDTH_CTRL:     readNext = lpWidthCtrl_reg;
			default:               readNext = 8'h00;
		endcase
	end

	// Misc bits 3-2 of 00 pick switch bit 3, down to 11 picking bit 0.
	wire [1:0] switchIdx = 2'h3 - miscSenseSel;
	wire switchBit = virtualSwitch_reg[switchIdx];
	wire senseNext = virtualSwitch_reg[VSW_SENSE_SELECT] ? switchBit
		: senseComparator;

	wire offsetOn = panelMode.flatPanel & panelMode.syncOffsetEn;
	wire [9:0] hsyncNext = {1'b0, stdHsyncStart}
		+ (offsetOn ? {2'h0, syncStartOffset_reg} : 10'h000);

	// The four-bit path ignores panning bit 0 for compatibility.
	wire [2:0] panNext = videoIfCtrl_reg[VIF_PAN_FULL] ? 3'h7
		: 3'h6;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			regReadData         <= 8'h00;
			senseStatusBit      <= 1'b0;
			hsyncStartEff       <= 10'h000;
			rowOffsetActual     <= 9'h000;
			tallFontScanlines   <= 5'h00;
			tallFontA           <= 1'b0;
			nineDotVirtualWidth <= 8'h00;
			paletteBlankByDe    <= 1'b0;
			eightBitPath        <= 1'b0;
			panningMask         <= 3'h6;
			interlaceEn         <= 1'b0;
			halfLineValue       <= 8'h00;
		end else begin
			if (regAccess.read)
				regReadData <= readNext;
			senseStatusBit <= senseNext;
			hsyncStartEff  <= hsyncNext;
			rowOffsetActual <= {1'b0, altRowOffset_reg} + 9'h001;
			tallFontScanlines <= tallFontMax_reg[TALL_FONT_MSB:0];
			tallFontA <= videoIfCtrl_reg[VIF_TALL_FONT_A];
			nineDotVirtualWidth <= nineDotWidth_reg;
			paletteBlankByDe <= ~panelMode.flatPanel
				& videoIfCtrl_reg[VIF_BLANK_DE_SEL];
			eightBitPath <= videoIfCtrl_reg[VIF_EIGHT_BIT_PATH];
			panningMask <= videoIfCtrl_reg[VIF_EIGHT_BIT_PATH] ? panNext
				: 3'h6;
			interlaceEn <= crtGraphicsMode & ~panelMode.flatPanel
				& videoIfCtrl_reg[VIF_INTERLACE];
			halfLineValue <= halfLine_reg;
		end
	end

	// Frame marker generator, counted in horizontal syncs.
	pulse_state_type fmState_reg;
	pulse_state_type fmState_next;
	logic [7:0] fmCount_reg;
	logic [7:0] fmCount_next;

	wire fmDelayOff = lpWidthCtrl_reg[LPW_FM_DLY_OFF];
	wire [1:0] fmLines = panelMode.dualDrivePanel ? FM_LINES_DUAL
		: FM_LINES_SINGLE;
	wire fmStartNow = fmDelayOff
		| (frameMarkerDelay_reg == 8'h00);
	wire hs = timingEvents.hsyncPulse;

	always_comb begin
		fmState_next = fmState_reg;
		fmCount_next = fmCount_reg;
		if (!panelMode.flatPanel) begin
			fmState_next = PULSE_IDLE;
		end else if (timingEvents.fpVsyncPulse) begin
			if (fmStartNow) begin
				fmState_next = PULSE_ACTIVE;
				fmCount_next = {6'h00, fmLines};
			end else begin
				fmState_next = PULSE_DELAY;
				fmCount_next = frameMarkerDelay_reg;
			end
		end else if (hs) begin
			unique case (fmState_reg)
				PULSE_IDLE: begin
				end
				PULSE_DELAY: begin
					if (fmCount_reg == 8'h01) begin
						fmState_next = PULSE_ACTIVE;
						fmCount_next = {6'h00, fmLines};
					end else begin
						fmCount_next = fmCount_reg - 8'h01;
					end
				end
				PULSE_ACTIVE: begin
					if (fmCount_reg == 8'h01)
						fmState_next = PULSE_IDLE;
					fmCount_next = fmCount_reg - 8'h01;
				end
				default: fmState_next = PULSE_IDLE;
			endcase
		end
	end

	// Line pulse generator, counted in character clocks.
	pulse_state_type lpState_reg;
	pulse_state_type lpState_next;
	logic [8:0] lpCount_reg;
	logic [8:0] lpCount_next;

	wire [8:0] lpDelayComp = {lpWidthCtrl_reg[LPW_COMP_DLY_MSB],
		lpDelayComp_reg};
	wire [8:0] lpDelayNine = {lpWidthCtrl_reg[LPW_NINE_DLY_MSB],
		lpDelayNine_reg};
	wire [8:0] lpDelaySel = panelMode.nineDotText ? lpDelayNine
		: lpDelayComp;
	wire [8:0] lpWidth = {5'h00, lpWidthCtrl_reg[LPW_WIDTH_MSB:0]};
	wire lpDelayOff = lpWidthCtrl_reg[LPW_LP_DLY_OFF];
	wire ce = timingEvents.charClkEn;

	// Counters hold actual minus one, so each phase ends on count zero.
	always_comb begin
		lpState_next = lpState_reg;
		lpCount_next = lpCount_reg;
		if (!panelMode.flatPanel) begin
			lpState_next = PULSE_IDLE;
		end else if (timingEvents.fpBlankEndPulse) begin
			if (lpDelayOff) begin
				lpState_next = PULSE_ACTIVE;
				lpCount_next = lpWidth;
			end else begin
				lpState_next = PULSE_DELAY;
				lpCount_next = lpDelaySel;
			end
		end else if (ce) begin
			unique case (lpState_reg)
				PULSE_IDLE: begin
				end
				PULSE_DELAY: begin
					if (lpCount_reg == 9'h000) begin
						lpState_next = PULSE_ACTIVE;
						lpCount_next = lpWidth;
					end else begin
						lpCount_next = lpCount_reg - 9'h001;
					end
				end
				PULSE_ACTIVE: begin
					if (lpCount_reg == 9'h000)
						lpState_next = PULSE_IDLE;
					else
						lpCount_next = lpCount_reg - 9'h001;
				end
				default: lpState_next = PULSE_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fmState_reg <= PULSE_IDLE;
			fmCount_reg <= 8'h00;
			lpState_reg <= PULSE_IDLE;
			lpCount_reg <= 9'h000;
			frameMarker <= 1'b0;
			linePulse   <= 1'b0;
		end else begin
			fmState_reg <= fmState_next;
			fmCount_reg <= fmCount_next;
			lpState_reg <= lpState_next;
			lpCount_reg <= lpCount_next;
			frameMarker <= (fmState_next == PULSE_ACTIVE);
			linePulse   <= (lpState_next == PULSE_ACTIVE);
		end
	end

endmodule

// ===== tb/flat_panel_alt_timing_regs_properties.sv
/*
 * Concurrent checks on the flat panel extension register slice.
 * Assumes it is bound to the slice and sees the slice's ports only.
 */
module flat_panel_alt_timing_regs_checker (
	input wire logic                                 core_clk,
	input wire logic                                 reset_n,
	input wire fp_alt_timing_pkg::reg_access_type    regAccess,
	input wire fp_alt_timing_pkg::timing_events_type timingEvents,
	input wire fp_alt_timing_pkg::panel_mode_type    panelMode,
	input wire logic [1:0]                           miscSenseSel,
	input wire logic                                 senseComparator,
	input wire logic [8:0]                           stdHsyncStart,
	input wire logic                                 senseStatusBit,
	input wire logic [9:0]                           hsyncStartEff,
	input wire logic [8:0]                           rowOffsetActual,
	input wire logic                                 paletteBlankByDe,
	input wire logic [2:0]                           panningMask,
	input wire logic                                 frameMarker,
	input wire logic                                 linePulse
);
	import fp_alt_timing_pkg::*;
	// Mirrors every write; only the bits that the checks read matter.
	logic [7:0] shadow [256];
	logic [1:0] fmHs;
	logic [3:0] lpCe;
	wire logic [7:0] vsw = shadow[IDX_VIRTUAL_SWITCH];
	wire logic [7:0] vif = shadow[IDX_VIDEO_IF_CTRL];
	wire logic [7:0] lpw = shadow[IDX_LP_WIDTH_CTRL];
	wire logic [7:0] sso = shadow[IDX_SYNC_START_OFFSET];
	wire logic       offOn = panelMode.flatPanel && panelMode.syncOffsetEn;
	wire logic       senseW = vsw[7] ? vsw[2'd3 - miscSenseSel] :
		senseComparator;
	wire logic [9:0] syncW = {1'b0, stdHsyncStart} +
		(offOn ? {2'b00, sso} : 10'h000);
	wire logic       palW = !panelMode.flatPanel && vif[1];
	wire logic       pan8 = vif[4] && vif[6];
	wire logic       fmKeep = panelMode.dualDrivePanel && fmHs == 2'h0;
	wire logic       lpLast = lpCe == lpw[3:0];
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 256; i++)
				shadow[i] <= 8'h00;
			fmHs <= 2'h0;
			lpCe <= 4'h0;
		end else begin
			if (regAccess.write)
				shadow[regAccess.index] <= regAccess.data;
			if (!frameMarker || timingEvents.fpVsyncPulse)
				fmHs <= 2'h0;
			else if (timingEvents.hsyncPulse)
				fmHs <= fmHs + 2'h1;
			if (!linePulse || timingEvents.fpBlankEndPulse)
				lpCe <= 4'h0;
			else if (timingEvents.charClkEn)
				lpCe <= lpCe + 4'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence rowWrite;
		regAccess.write && regAccess.index == IDX_ALT_ROW_OFFSET;
	endsequence
	sequence fmImm;
		panelMode.flatPanel && timingEvents.fpVsyncPulse &&
		(lpw[7] || shadow[IDX_FRAME_MARKER_DLY] == 8'h00);
	endsequence
	sequence lpImm;
		panelMode.flatPanel && timingEvents.fpBlankEndPulse && lpw[6];
	endsequence
	AST_ROW_OFFSET: assert property (
		rowWrite |-> ##2
		rowOffsetActual == {1'b0, $past(regAccess.data, 2)} + 9'h001)
		else $error("row offset is not the stored value plus one");
	AST_SENSE: assert property (
		$past(reset_n) |-> senseStatusBit == $past(senseW))
		else $error("sense status bit from the wrong source");
	AST_SYNC_OFFSET: assert property (
		$past(reset_n) |-> hsyncStartEff == $past(syncW))
		else $error("effective sync start is wrong");
	AST_PALETTE: assert property (
		$changed(palW) |=> paletteBlankByDe == $past(palW))
		else $error("palette blanking source is wrong");
	AST_PANNING: assert property (
		$past(reset_n) |-> panningMask == ($past(pan8) ? 3'b111 : 3'b110))
		else $error("pixel panning mask is wrong");
	AST_FM_IMMEDIATE: assert property (
		fmImm |=> frameMarker)
		else $error("frame marker did not follow vsync at once");
	AST_FM_LENGTH: assert property (
		frameMarker && timingEvents.hsyncPulse &&
		!timingEvents.fpVsyncPulse |=> frameMarker == $past(fmKeep))
		else $error("frame marker length in lines is wrong");
	AST_LP_IMMEDIATE: assert property (
		lpImm |=> linePulse)
		else $error("line pulse did not follow blank end at once");
	AST_LP_WIDTH: assert property (
		linePulse && timingEvents.charClkEn &&
		!timingEvents.fpBlankEndPulse |=> linePulse != $past(lpLast))
		else $error("line pulse width is wrong");
endmodule

bind flat_panel_alt_timing_regs flat_panel_alt_timing_regs_checker u_checker (
	.core_clk, .reset_n, .regAccess, .timingEvents, .panelMode,
	.miscSenseSel, .senseComparator, .stdHsyncStart, .senseStatusBit,
	.hsyncStartEff, .rowOffsetActual, .paletteBlankByDe, .panningMask,
	.frameMarker, .linePulse
);

// ===== tb/fp_panel_model.sv
/*
 * Behavioural panel that measures the frame marker and line pulse.
 * Assumes the timing events and both pulses share core_clk.
 */
module fp_panel_model (
	input  wire logic                                 core_clk,
	input  wire logic                                 reset_n,
	input  wire fp_alt_timing_pkg::timing_events_type timingEvents,
	input  wire logic                                 frameMarker,
	input  wire logic                                 linePulse,
	output logic [9:0]                                fmDelay,
	output logic [9:0]                                fmLines,
	output logic [9:0]                                lpDelay,
	output logic [9:0]                                lpClks
);
	import fp_alt_timing_pkg::*;
	logic [9:0] hsSince;
	logic [9:0] ceSince;
	logic       fmPrev;
	logic       lpPrev;
	// Counts restart on each vsync or blank end, as a real panel would.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{hsSince, ceSince, fmPrev, lpPrev} <= '0;
			{fmDelay, fmLines, lpDelay, lpClks} <= '0;
		end else begin
			fmPrev <= frameMarker;
			lpPrev <= linePulse;
			if (timingEvents.fpVsyncPulse)
				hsSince <= 10'h000;
			else if (timingEvents.hsyncPulse)
				hsSince <= hsSince + 10'h001;
			if (timingEvents.fpBlankEndPulse)
				ceSince <= 10'h000;
			else if (timingEvents.charClkEn)
				ceSince <= ceSince + 10'h001;
			if (frameMarker && !fmPrev) begin
				fmDelay <= hsSince;
				fmLines <= 10'h000;
			end else if (frameMarker && timingEvents.hsyncPulse)
				fmLines <= fmLines + 10'h001;
			if (linePulse && !lpPrev) begin
				lpDelay <= ceSince;
				lpClks <= 10'h000;
			end else if (linePulse && timingEvents.charClkEn)
				lpClks <= lpClks + 10'h001;
		end
	end
endmodule

// ===== tb/flat_panel_alt_timing_regs_test.sv
/*
 * Self-checking bench for the flat panel extension register slice.
 * Assumes the slice, its checker and the panel model are compiled first.
 */
module flat_panel_alt_timing_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	import fp_alt_timing_pkg::*;
	localparam logic [7:0] IDX [13] = '{8'h1e, 8'h1f, 8'h24, 8'h25, 8'h26,
		8'h28, 8'h29, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h20};
	localparam logic [7:0] FM_N [4] = '{8'h05, 8'h00, 8'h03, 8'h02};
	localparam logic [7:0] LP_C [4] = '{8'h00, 8'h02, 8'h02, 8'h09};
	localparam logic [7:0] LP_N [4] = '{8'h00, 8'h07, 8'h04, 8'h00};
	localparam logic [7:0] LP_W [4] = '{8'h40, 8'h2f, 8'h23, 8'h10};
	localparam logic [9:0] EXP_D [4] = '{10'h000, 10'h103, 10'h005, 10'h101};
	localparam logic [9:0] EXP_W [4] = '{10'h001, 10'h010, 10'h004, 10'h001};
	logic              core_clk = 1'b0;
	logic              reset_n = 1'b0;
	reg_access_type    regAccess = '0;
	timing_events_type timingEvents = '0;
	panel_mode_type    panelMode = '0;
	logic              crtGraphicsMode = 1'b0;
	logic [1:0]        miscSenseSel = 2'h0;
	logic              senseComparator = 1'b0;
	logic [8:0]        stdHsyncStart = 9'h000;
	logic [7:0]        stdRowOffset = 8'h3c;
	logic [7:0]        regReadData, halfLineValue, nineDotVirtualWidth;
	logic [9:0]        hsyncStartEff, fmDelay, fmLines, lpDelay, lpClks;
	logic [8:0]        rowOffsetActual;
	logic [4:0]        tallFontScanlines;
	logic [2:0]        panningMask;
	logic              senseStatusBit, tallFontA, paletteBlankByDe;
	logic              eightBitPath, interlaceEn, frameMarker, linePulse;
	int                fails = 0;
	int                compares = 0;
	always #5 core_clk = ~core_clk;
	flat_panel_alt_timing_regs u_dut (.core_clk, .reset_n, .regAccess,
		.timingEvents, .panelMode, .crtGraphicsMode, .miscSenseSel,
		.senseComparator, .stdHsyncStart, .stdRowOffset, .regReadData,
		.senseStatusBit, .hsyncStartEff, .rowOffsetActual,
		.tallFontScanlines, .tallFontA, .nineDotVirtualWidth,
		.paletteBlankByDe, .eightBitPath, .panningMask, .interlaceEn,
		.halfLineValue, .frameMarker, .linePulse);
	fp_panel_model u_panel (.core_clk, .reset_n, .timingEvents,
		.frameMarker, .linePulse, .fmDelay, .fmLines, .lpDelay, .lpClks);
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		regAccess = '{1'b1, 1'b0, idx, val};
		@(negedge core_clk);
		regAccess = '0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		regAccess = '{1'b0, 1'b1, idx, 8'h00};
		@(negedge core_clk);
		regAccess = '0;
		@(negedge core_clk);
		chk(regReadData, exp);
	endtask
	task automatic pulse(input timing_events_type ev, input int n);
		repeat (n) begin
			timingEvents = ev;
			@(negedge core_clk);
			timingEvents = '0;
			@(negedge core_clk);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		stop_test();
	end
	initial begin
		repeat (6) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		chk(panningMask, 3'b110);
		for (int i = 0; i < 13; i++) begin
			rd(IDX[i], 8'h00);
			wr(IDX[i], 8'ha5);
			rd(IDX[i], i == 1 ? 8'h85 : i == 5 ? 8'ha0 : i == 12 ? 8'h00 :
				8'ha5);
		end
		chk(rowOffsetActual, 9'h0a6);
		chk(tallFontScanlines, 5'h05);
		chk(halfLineValue, 8'ha5);
		// An 80-character panel gives nine eighths of 80, minus one.
		wr(8'h25, 8'h59);
		chk(nineDotVirtualWidth, 8'h59);
		$display("test registers done");
		crtGraphicsMode = 1'b1;
		for (int v = 0; v < 2; v++) begin
			wr(8'h28, v ? 8'hf2 : 8'h00);
			chk(paletteBlankByDe, v[0]);
			chk(eightBitPath, v[0]);
			chk(panningMask, {2'b11, v[0]});
			chk(interlaceEn, v[0]);
			chk(tallFontA, v[0]);
		end
		panelMode.flatPanel = 1'b1;
		wr(8'h26, 8'hf0);
		stdHsyncStart = 9'h1f0;
		chk(paletteBlankByDe, 1'b0);
		chk(interlaceEn, 1'b0);
		for (int s = 0; s < 2; s++) begin
			panelMode.syncOffsetEn = s[0];
			@(negedge core_clk);
			chk(hsyncStartEff, s ? 10'h2e0 : 10'h1f0);
		end
		wr(8'h1f, 8'h84);
		for (int m = 0; m < 4; m++) begin
			miscSenseSel = m[1:0];
			senseComparator = ~m[0];
			@(negedge core_clk);
			chk(senseStatusBit, m == 1);
		end
		wr(8'h1f, 8'h0f);
		for (int c = 0; c < 2; c++) begin
			senseComparator = c[0];
			@(negedge core_clk);
			chk(senseStatusBit, c[0]);
		end
		$display("test video and sense done");
		for (int k = 0; k < 4; k++) begin
			wr(8'h2f, k == 0 ? 8'h80 : 8'h00);
			wr(8'h2c, FM_N[k]);
			panelMode.dualDrivePanel = k[0];
			pulse(4'h2, 1);
			pulse(4'h4, 6);
			chk(fmDelay, k == 0 ? 8'h00 : FM_N[k]);
			chk(fmLines, k[0] ? 10'h002 : 10'h001);
		end
		$display("test frame marker done");
		for (int k = 0; k < 4; k++) begin
			wr(8'h2d, LP_C[k]);
			wr(8'h2e, LP_N[k]);
			wr(8'h2f, LP_W[k]);
			panelMode.nineDotText = k[1];
			panelMode.hCompress = !k[1];
			pulse(4'h1, 1);
			pulse(4'h8, 280);
			chk(lpDelay, EXP_D[k]);
			chk(lpClks, EXP_W[k]);
		end
		// A dual-drive panel gets the same line pulse delay, the register value plus one.
		panelMode.dualDrivePanel = 1'b1;
		panelMode.nineDotText = 1'b0;
		wr(8'h2d, 8'h04);
		wr(8'h2f, 8'h00);
		pulse(4'h1, 1);
		pulse(4'h8, 8);
		chk(lpDelay, 10'h005);
		$display("test line pulse done");
		reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		rd(8'h2b, 8'h00);
		$display("test second reset done");
		stop_test();
	end
endmodule
